// File: hw/ao_sequencer.sv
// Analog output sequencer: register port, sample FIFO, pacing, triggers.
// Assumes synchronous inputs, a one-cycle 48 MHz ref_tick strobe and
// an external converter that takes a code on each load pulse.
`timescale 1ns/10ps

// Summary of operation
// - Channel 0 always, channel 1 on dual variant
// - Outputs hold zero-volt code after reset
// - Software selects narrow or wide range
// - Samples are fixed 32-bit words
// - Pacing counts 48 MHz reference ticks
// - Sample rate held within 30-216 kHz
// - First sample after 36 sample ticks
// - Single value applied at once, unstoppable
// - Waveform starts only on software trigger, or on link trigger as sync slave
// - Waveform read pointer wraps to start
// - Mute ramps to zero over 1020 samples
// - Continuous mode emits queued samples until done
// - Empty FIFO on demand flags underrun event
// - Orderly stop finishes count, then ignores triggers
// - Abrupt stop halts now, ignores triggers
// - Trigger: software, external rising or falling
// - Sync slave uses link trigger and clock only
// - Codes are offset binary
// - One start may also start analog input
// - FIFO refill while running keeps output gap-free
// - Sync none uses internal pacing
module ao_sequencer #(
  parameter bit DUAL_VARIANT  = 1'b1,
  parameter bit WIDE_RANGE_OK = 1'b1
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        srst,
  // Register port
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  output logic      [31:0] rdata,
  // Timing and triggers
  input  wire logic        ref_tick,
  input  wire logic        ext_trig,
  input  wire logic        sync_trig_in,
  input  wire logic        sync_clk_in,
  output logic             sync_trig_out,
  output logic             sync_clk_out,
  // Converter side
  output logic      [31:0] dac_code0,
  output logic      [31:0] dac_code1,
  output logic             dac_load0,
  output logic             dac_load1,
  output logic             range_wide,
  // Status
  output logic             underrun_evt,
  output logic             ai_start,
  output logic             running
);

  typedef enum logic [2:0] {ST_IDLE, ST_ARMED, ST_WARMUP, ST_RUN, ST_HALT} state_t;

  //----------------------------------------------------------------
  // Registers and decode
  //----------------------------------------------------------------
  logic [31:0]                      ctrl_reg;
  logic [ao_seq_pkg::DIV_W-1:0]     div_reg;
  logic [ao_seq_pkg::CNT_W-1:0]     stopn_reg;
  logic                             schan_reg;
  state_t                           state_reg;
  logic [31:0]                      mem [ao_seq_pkg::FIFO_DEPTH];
  logic [ao_seq_pkg::PTR_W-1:0]     wr_ptr_reg;
  logic [ao_seq_pkg::PTR_W-1:0]     rd_ptr_reg;
  logic [ao_seq_pkg::PTR_W-1:0]     level;
  logic [ao_seq_pkg::DIV_W-1:0]     div_cnt_reg;
  logic [5:0]                       warm_reg;
  logic [ao_seq_pkg::CNT_W-1:0]     left_reg;
  logic                             drain_reg;
  logic                             underrun_reg;
  logic                             ext_q;
  logic                             sclk_q;
  logic                             strig_q;
  logic                             ch1_pend_reg;
  logic [31:0]                      smp_reg;
  logic                             smp_vld_reg;
  logic                             smp_ch_reg;
  logic [31:0]                      muted;
  logic                             silent;
  ao_seq_pkg::mode_t                mode;
  ao_seq_pkg::trig_t                trig_sel;
  ao_seq_pkg::sync_t                sync_sel;
  logic                             dual;
  logic                             wr_ctrl;
  logic                             wr_cmd;
  logic                             cmd_start;
  logic                             cmd_orderly;
  logic                             cmd_abrupt;
  logic                             cmd_clear;
  logic                             trig_hit;
  logic                             tick;
  logic                             emit;
  logic                             empty;
  logic                             full;
  logic                             pop;
  logic                             underrun;
  logic                             active;

  function automatic logic [ao_seq_pkg::DIV_W-1:0] clamp_div(input logic [31:0] v);
    if (v < 32'(ao_seq_pkg::DIV_MIN)) begin
      return ao_seq_pkg::DIV_MIN;
    end else if (v > 32'(ao_seq_pkg::DIV_MAX)) begin
      return ao_seq_pkg::DIV_MAX;
    end
    return v[ao_seq_pkg::DIV_W-1:0];
  endfunction : clamp_div

  assign mode        = ao_seq_pkg::mode_t'(ctrl_reg[ao_seq_pkg::F_MODE +: 2]);
  assign trig_sel    = ao_seq_pkg::trig_t'(ctrl_reg[ao_seq_pkg::F_TRIG +: 2]);
  assign sync_sel    = ao_seq_pkg::sync_t'(ctrl_reg[ao_seq_pkg::F_SYNC +: 2]);
  assign dual        = ctrl_reg[ao_seq_pkg::F_DUAL] & DUAL_VARIANT;
  assign range_wide  = ctrl_reg[ao_seq_pkg::F_WIDE] & WIDE_RANGE_OK;
  assign wr_ctrl     = wr_stb && addr == ao_seq_pkg::REG_CTRL;
  assign wr_cmd      = wr_stb && addr == ao_seq_pkg::REG_CMD;
  assign cmd_start   = wr_cmd && (wdata[ao_seq_pkg::C_START] || wdata[ao_seq_pkg::C_START_ALL]);
  assign cmd_orderly = wr_cmd && wdata[ao_seq_pkg::C_ORDERLY];
  assign cmd_abrupt  = wr_cmd && wdata[ao_seq_pkg::C_ABRUPT];
  assign cmd_clear   = wr_cmd && wdata[ao_seq_pkg::C_CLEAR];
  assign active      = state_reg == ST_WARMUP || state_reg == ST_RUN;
  assign running     = active;

  always_ff @(posedge mclk) begin
    if (srst) begin
      ctrl_reg  <= 32'h0000_0000;
      div_reg   <= ao_seq_pkg::DIV_MAX;
      stopn_reg <= 16'h0000;
      schan_reg <= 1'b0;
    end else if (wr_stb) begin
      unique case (addr)
        ao_seq_pkg::REG_CTRL:  ctrl_reg  <= {23'h0, wdata[8:0]};
        ao_seq_pkg::REG_RATE:  div_reg   <= clamp_div(wdata);
        ao_seq_pkg::REG_STOPN: stopn_reg <= wdata[ao_seq_pkg::CNT_W-1:0];
        ao_seq_pkg::REG_SCHAN: schan_reg <= wdata[0] & DUAL_VARIANT;
        default: ;
      endcase
    end
  end

  //----------------------------------------------------------------
  // Triggers and pacing
  //----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      ext_q   <= 1'b0;
      sclk_q  <= 1'b0;
      strig_q <= 1'b0;
    end else begin
      ext_q   <= ext_trig;
      sclk_q  <= sync_clk_in;
      strig_q <= sync_trig_in;
    end
  end

  always_comb begin
    if (sync_sel == ao_seq_pkg::SYNC_SLAVE) begin
      trig_hit = sync_trig_in && !strig_q;
    end else if (mode == ao_seq_pkg::MODE_WAVE) begin
      trig_hit = cmd_start;
    end else begin
      unique case (trig_sel)
        ao_seq_pkg::TRIG_EXT_RISE: trig_hit = ext_trig && !ext_q;
        ao_seq_pkg::TRIG_EXT_FALL: trig_hit = !ext_trig && ext_q;
        default:                   trig_hit = cmd_start;
      endcase
    end
  end

  // Sample tick from link clock as slave, else from reference divider
  assign tick = active && ((sync_sel == ao_seq_pkg::SYNC_SLAVE) ? (sync_clk_in && !sclk_q)
                : (ref_tick && div_cnt_reg == div_reg - 11'h001));

  always_ff @(posedge mclk) begin
    if (srst || !active) begin
      div_cnt_reg <= 11'h000;
    end else if (ref_tick) begin
      div_cnt_reg <= (div_cnt_reg == div_reg - 11'h001) ? 11'h000 : div_cnt_reg + 11'h001;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      sync_trig_out <= 1'b0;
      sync_clk_out  <= 1'b0;
      ai_start      <= 1'b0;
    end else begin
      sync_trig_out <= sync_sel == ao_seq_pkg::SYNC_MASTER && state_reg != ST_HALT && trig_hit;
      sync_clk_out  <= sync_sel == ao_seq_pkg::SYNC_MASTER && tick;
      ai_start      <= wr_cmd && wdata[ao_seq_pkg::C_START_ALL] && state_reg == ST_IDLE;
    end
  end

  //----------------------------------------------------------------
  // Sequencing
  //----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_reg <= ST_IDLE;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (cmd_start && (mode == ao_seq_pkg::MODE_WAVE || mode == ao_seq_pkg::MODE_CONT)) begin
            state_reg <= (sync_sel != ao_seq_pkg::SYNC_SLAVE && trig_hit) ? ST_WARMUP : ST_ARMED;
          end
        end
        ST_ARMED: begin
          if (cmd_abrupt || cmd_orderly) begin
            state_reg <= ST_HALT;
          end else if (trig_hit) begin
            state_reg <= ST_WARMUP;
          end
        end
        ST_WARMUP: begin
          if (cmd_abrupt) begin
            state_reg <= ST_HALT;
          end else if (tick && warm_reg == ao_seq_pkg::WARMUP_TICKS - 6'h01) begin
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (cmd_abrupt || underrun || (drain_reg && left_reg == 16'h0000)) begin
            state_reg <= ST_HALT;
          end
        end
        ST_HALT: begin
          if (wr_ctrl || cmd_clear) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst || state_reg != ST_WARMUP) begin
      warm_reg <= 6'h00;
    end else if (tick) begin
      warm_reg <= warm_reg + 6'h01;
    end
  end

  // Orderly stop: count down emitted samples
  always_ff @(posedge mclk) begin
    if (srst || state_reg == ST_IDLE) begin
      drain_reg <= 1'b0;
      left_reg  <= 16'h0000;
    end else if (cmd_orderly && active && !drain_reg) begin
      drain_reg <= 1'b1;
      left_reg  <= stopn_reg;
    end else if (drain_reg && pop && left_reg != 16'h0000) begin
      left_reg  <= left_reg - 16'h0001;
    end
  end

  //----------------------------------------------------------------
  // Sample FIFO
  //----------------------------------------------------------------
  assign level    = wr_ptr_reg - rd_ptr_reg;
  assign full     = (mode == ao_seq_pkg::MODE_WAVE) ? wr_ptr_reg == 14'(ao_seq_pkg::FIFO_DEPTH)
                    : level == 14'(ao_seq_pkg::FIFO_DEPTH);
  assign empty    = (mode == ao_seq_pkg::MODE_WAVE) ? wr_ptr_reg == 14'h0000 : level == 14'h0000;
  assign emit     = state_reg == ST_RUN && !cmd_abrupt && !(drain_reg && left_reg == 16'h0000)
                    && (tick || ch1_pend_reg);
  assign pop      = emit && !empty;
  assign underrun = emit && empty;

  // Channel 1 follows channel 0 one cycle later in each frame
  always_ff @(posedge mclk) begin
    if (srst) begin
      ch1_pend_reg <= 1'b0;
    end else begin
      ch1_pend_reg <= tick && dual && state_reg == ST_RUN;
    end
  end

  always_ff @(posedge mclk) begin
    if (wr_stb && addr == ao_seq_pkg::REG_FDATA && !full) begin
      mem[wr_ptr_reg[ao_seq_pkg::MEM_AW-1:0]] <= wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst || cmd_clear) begin
      wr_ptr_reg <= 14'h0000;
    end else if (wr_stb && addr == ao_seq_pkg::REG_FDATA && !full) begin
      wr_ptr_reg <= wr_ptr_reg + 14'h0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst || cmd_clear) begin
      rd_ptr_reg <= 14'h0000;
    end else if (cmd_start && state_reg == ST_IDLE && mode == ao_seq_pkg::MODE_WAVE) begin
      rd_ptr_reg <= 14'h0000;
    end else if (pop && mode == ao_seq_pkg::MODE_WAVE) begin
      rd_ptr_reg <= (rd_ptr_reg + 14'h0001 == wr_ptr_reg) ? 14'h0000 : rd_ptr_reg + 14'h0001;
    end else if (pop) begin
      rd_ptr_reg <= rd_ptr_reg + 14'h0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      smp_vld_reg <= 1'b0;
      smp_ch_reg  <= 1'b0;
      smp_reg     <= ao_seq_pkg::ZERO_CODE;
    end else begin
      smp_vld_reg <= pop;
      smp_ch_reg  <= ch1_pend_reg;
      smp_reg     <= mem[rd_ptr_reg[ao_seq_pkg::MEM_AW-1:0]];
    end
  end

  // Underrun: sticky flag, set wins over the clear by a new start
  always_ff @(posedge mclk) begin
    if (srst) begin
      underrun_reg <= 1'b0;
      underrun_evt <= 1'b0;
    end else begin
      underrun_evt <= underrun;
      if (underrun) begin
        underrun_reg <= 1'b1;
      end else if (cmd_start && state_reg == ST_IDLE) begin
        underrun_reg <= 1'b0;
      end
    end
  end

  //----------------------------------------------------------------
  // Converter outputs
  //----------------------------------------------------------------
  mute_ramp u_ramp (
    .mclk       (mclk),
    .srst       (srst),
    .mute       (ctrl_reg[ao_seq_pkg::F_MUTE]),
    .step       (smp_vld_reg && !smp_ch_reg),
    .sample_in  (smp_reg),
    .sample_out (muted),
    .silent     (silent)
  );

  always_ff @(posedge mclk) begin
    if (srst) begin
      dac_code0 <= ao_seq_pkg::ZERO_CODE;
      dac_code1 <= ao_seq_pkg::ZERO_CODE;
      dac_load0 <= 1'b0;
      dac_load1 <= 1'b0;
    end else if (wr_stb && addr == ao_seq_pkg::REG_SVALUE && mode == ao_seq_pkg::MODE_SINGLE) begin
      dac_load0 <= !schan_reg;
      dac_load1 <= schan_reg;
      if (schan_reg) begin
        dac_code1 <= wdata;
      end else begin
        dac_code0 <= wdata;
      end
    end else begin
      dac_load0 <= smp_vld_reg && !smp_ch_reg;
      dac_load1 <= smp_vld_reg && smp_ch_reg;
      if (smp_vld_reg && smp_ch_reg) begin
        dac_code1 <= muted;
      end else if (smp_vld_reg) begin
        dac_code0 <= muted;
      end
    end
  end

  //----------------------------------------------------------------
  // Read port
  //----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst || !rd_stb) begin
      rdata <= 32'h0000_0000;
    end else begin
      unique case (addr)
        ao_seq_pkg::REG_CTRL:   rdata <= ctrl_reg;
        ao_seq_pkg::REG_RATE:   rdata <= {21'h0, div_reg};
        ao_seq_pkg::REG_SCHAN:  rdata <= {31'h0, schan_reg};
        ao_seq_pkg::REG_STOPN:  rdata <= {16'h0, stopn_reg};
        ao_seq_pkg::REG_STATUS: rdata <= {25'h0, silent, drain_reg, underrun_reg, 1'b0, state_reg};
        ao_seq_pkg::REG_LEVEL:  rdata <= {18'h0, level};
        default:                rdata <= 32'h0000_0000;
      endcase
    end
  end

  //----------------------------------------------------------------
  // Assertions
  //----------------------------------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);

  a_reset_zero_code: assert property ($fell(srst) |-> dac_code0 == ao_seq_pkg::ZERO_CODE
    && dac_code1 == ao_seq_pkg::ZERO_CODE) else $error("codes not zero after reset");
  a_rate_in_range: assert property (div_reg >= ao_seq_pkg::DIV_MIN && div_reg <= ao_seq_pkg::DIV_MAX)
    else $error("divider out of range");
  a_warmup_no_load: assert property (state_reg == ST_WARMUP |-> ##2 !dac_load0 || $past(state_reg, 2) != ST_WARMUP)
    else $error("load during warmup");
  a_single_apply: assert property (wr_stb && addr == ao_seq_pkg::REG_SVALUE && mode == ao_seq_pkg::MODE_SINGLE
    |=> ($past(schan_reg) ? dac_load1 && dac_code1 == $past(wdata) : dac_load0 && dac_code0 == $past(wdata)))
    else $error("single value not applied");
  a_wave_wrap: assert property (pop && mode == ao_seq_pkg::MODE_WAVE && rd_ptr_reg + 14'h0001 == wr_ptr_reg
    && !cmd_clear |=> rd_ptr_reg == 14'h0000) else $error("waveform did not wrap");
  a_underrun_flag: assert property (underrun |=> underrun_reg && underrun_evt ##1 !running)
    else $error("underrun not reported");
  a_abrupt_halt: assert property (cmd_abrupt && state_reg inside {ST_ARMED, ST_WARMUP, ST_RUN}
    |=> state_reg == ST_HALT ##1 !dac_load0 && !dac_load1) else $error("abrupt stop ignored");
  a_halt_ignores: assert property (state_reg == ST_HALT && !wr_ctrl && !cmd_clear
    |=> state_reg == ST_HALT) else $error("trigger left halt");
  a_slave_ext_ignored: assert property (sync_sel == ao_seq_pkg::SYNC_SLAVE && state_reg == ST_ARMED
    && !(sync_trig_in && !strig_q) |=> state_reg != ST_WARMUP) else $error("slave took other trigger");
  a_start_clears: assert property (cmd_start && state_reg == ST_IDLE && !underrun
    |=> !underrun_reg) else $error("underrun not cleared on start");

  c_wave_wrap: cover property (pop && mode == ao_seq_pkg::MODE_WAVE && rd_ptr_reg + 14'h0001 == wr_ptr_reg);
  c_underrun: cover property (underrun_evt);
  c_orderly_done: cover property (drain_reg && state_reg == ST_RUN ##1 state_reg == ST_HALT);
  c_mute_silent: cover property ($rose(silent));

endmodule : ao_sequencer

// File: hw/ao_seq_pkg.sv
// Constants, register map and types of the analog output sequencer.
// Assumes a 50 MHz system clock and a 48 MHz reference tick strobe.
package ao_seq_pkg;

  //----------------------------------------------------------------
  // Sizes and codes
  //----------------------------------------------------------------
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned FIFO_DEPTH = 8192;
  localparam int unsigned PTR_W      = 14;
  localparam int unsigned MEM_AW     = 13;
  localparam int unsigned ADDR_W     = 4;
  localparam int unsigned DIV_W      = 11;
  localparam int unsigned CNT_W      = 16;
  localparam logic [31:0] ZERO_CODE  = 32'h8000_0000;

  //----------------------------------------------------------------
  // Pacing
  //----------------------------------------------------------------
  localparam int unsigned REF_HZ     = 48_000_000;
  localparam int unsigned FS_MIN_HZ  = 30_000;
  localparam int unsigned FS_MAX_HZ  = 216_000;
  localparam logic [DIV_W-1:0] DIV_MIN = DIV_W'((REF_HZ + FS_MAX_HZ - 1) / FS_MAX_HZ);
  localparam logic [DIV_W-1:0] DIV_MAX = DIV_W'(REF_HZ / FS_MIN_HZ);
  localparam logic [5:0]  WARMUP_TICKS = 6'h24;
  localparam logic [10:0] MUTE_STEPS   = 11'h3FC;

  //----------------------------------------------------------------
  // Register indices
  //----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_CTRL   = 4'h0;
  localparam logic [ADDR_W-1:0] REG_RATE   = 4'h1;
  localparam logic [ADDR_W-1:0] REG_CMD    = 4'h2;
  localparam logic [ADDR_W-1:0] REG_SCHAN  = 4'h3;
  localparam logic [ADDR_W-1:0] REG_SVALUE = 4'h4;
  localparam logic [ADDR_W-1:0] REG_FDATA  = 4'h5;
  localparam logic [ADDR_W-1:0] REG_STOPN  = 4'h6;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h7;
  localparam logic [ADDR_W-1:0] REG_LEVEL  = 4'h8;

  //----------------------------------------------------------------
  // Field positions
  //----------------------------------------------------------------
  localparam int unsigned F_MODE = 0;
  localparam int unsigned F_TRIG = 2;
  localparam int unsigned F_SYNC = 4;
  localparam int unsigned F_WIDE = 6;
  localparam int unsigned F_MUTE = 7;
  localparam int unsigned F_DUAL = 8;
  localparam int unsigned C_START     = 0;
  localparam int unsigned C_START_ALL = 1;
  localparam int unsigned C_ORDERLY   = 2;
  localparam int unsigned C_ABRUPT    = 3;
  localparam int unsigned C_CLEAR     = 4;

  typedef enum logic [1:0] {MODE_SINGLE, MODE_WAVE, MODE_CONT, MODE_RSVD} mode_t;
  typedef enum logic [1:0] {TRIG_SW, TRIG_EXT_RISE, TRIG_EXT_FALL, TRIG_RSVD} trig_t;
  typedef enum logic [1:0] {SYNC_NONE, SYNC_MASTER, SYNC_SLAVE, SYNC_RSVD} sync_t;

endpackage : ao_seq_pkg

// File: hw/mute_ramp.sv
// Mute ramp: scales samples toward the zero-volt code over a fixed count.
// Assumes one step pulse per output frame and offset binary samples.
`timescale 1ns/10ps
module mute_ramp (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        srst,
  // Control
  input  wire logic        mute,
  input  wire logic        step,
  // Samples
  input  wire logic [31:0] sample_in,
  output logic      [31:0] sample_out,
  output logic             silent
);

  logic        [10:0] gain_reg;
  logic signed [32:0] diff;
  logic signed [44:0] scaled;

  // Gain steps down once per frame while muted; unmute restores at once
  always_ff @(posedge mclk) begin
    if (srst || !mute) begin
      gain_reg <= ao_seq_pkg::MUTE_STEPS;
    end else if (step && gain_reg != 11'h000) begin
      gain_reg <= gain_reg - 11'h001;
    end
  end

  // Offset binary: scale the distance from the zero code
  always_comb begin
    diff       = $signed({1'b0, sample_in}) - $signed({1'b0, ao_seq_pkg::ZERO_CODE});
    scaled     = (45'(diff) * $signed({34'h0, gain_reg})) / $signed({34'h0, ao_seq_pkg::MUTE_STEPS});
    sample_out = ao_seq_pkg::ZERO_CODE + scaled[31:0];
  end

  assign silent = (gain_reg == 11'h000);

endmodule : mute_ramp

// File: bench/host_model.sv
// Host side model: register bus master of the sequencer.
// Assumes tasks are called from one bench process at a time.
`timescale 1ns/10ps
module host_model (
  // Clock
  input  wire logic        mclk,
  // Register port
  output logic      [3:0]  addr,
  output logic      [31:0] wdata,
  output logic             wr_stb,
  output logic             rd_stb,
  input  wire logic [31:0] rdata
);
  initial begin
    addr   = 4'h0;
    wdata  = 32'h0;
    wr_stb = 1'h0;
    rd_stb = 1'h0;
  end

  // Host writes one word to the addressed register per call
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'h1;
    @(posedge mclk);
    wr_stb <= 1'h0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk);
    addr   <= a;
    rd_stb <= 1'h1;
    @(posedge mclk);
    rd_stb <= 1'h0;
    #1 d = rdata;
  endtask : rd
endmodule : host_model

// File: bench/testbench.sv
// Self-checking bench of the analog output sequencer.
// Assumes host_model drives the register port.
`timescale 1ns/10ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin mismatches++; \
  $display("Error t=%0t got %h exp %h", $time, (a), (b)); end end
module testbench;
  logic        mclk = 1'h0, srst = 1'h1, ref_tick = 1'h0, ext_trig = 1'h0;
  logic [4:0]  tick_cnt = 5'h0;
  logic [3:0]  addr;
  logic [31:0] wdata, rdata, dac_code0, dac_code1, d;
  logic        wr_stb, rd_stb, dac_load0, dac_load1, underrun_evt, running, range_wide, ai_start;
  logic        strig = 1'h0, sclk = 1'h0;
  int          mismatches = 0, samples_checked = 0, c;

  initial begin
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    tick_cnt <= (tick_cnt == 5'h18) ? 5'h0 : tick_cnt + 5'h1;
    ref_tick <= (tick_cnt != 5'h18);
  end

  host_model host (.mclk(mclk), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata));
  ao_sequencer i_ao_sequencer (.mclk(mclk), .srst(srst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .ref_tick(ref_tick), .ext_trig(ext_trig), .sync_trig_in(strig),
    .sync_clk_in(sclk), .sync_trig_out(), .sync_clk_out(), .dac_code0(dac_code0), .dac_code1(dac_code1),
    .dac_load0(dac_load0), .dac_load1(dac_load1), .range_wide(range_wide), .underrun_evt(underrun_evt),
    .ai_start(ai_start), .running(running));

  task automatic wait_load(input int n);
    @(posedge mclk);
    #1 c = 0;
    while (dac_load0 !== 1'h1 && c < n) begin
      @(posedge mclk);
      #1 c++;
    end
  endtask : wait_load

  task automatic stop_test();
    $display("Checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test

  initial begin
    repeat (60000) @(posedge mclk);
    mismatches++;
    stop_test();
  end

  task automatic link_tick();
    sclk <= 1'h0;
    @(posedge mclk);
    sclk <= 1'h1;
    wait_load(8);
  endtask : link_tick

  task automatic t_reset();
    repeat (8) @(posedge mclk);
    srst <= 1'h0;
    `CHK(dac_code0, ao_seq_pkg::ZERO_CODE)
    host.rd(ao_seq_pkg::REG_RATE, d);
    `CHK(d, 32'h640)
    host.rd(4'hF, d);
    `CHK(d, 32'h0)
  endtask : t_reset

  task automatic t_single();
    host.wr(ao_seq_pkg::REG_SVALUE, 32'h0F0F5A5A);
    #1 `CHK(dac_load0, 1'h1)
    `CHK(dac_code0, 32'h0F0F5A5A)
    host.wr(ao_seq_pkg::REG_SCHAN, 32'h1);
    host.wr(ao_seq_pkg::REG_SVALUE, 32'h1234ABCD);
    #1 `CHK(dac_load1, 1'h1)
    `CHK(dac_code1, 32'h1234ABCD)
  endtask : t_single

  task automatic t_wave();
    host.wr(ao_seq_pkg::REG_CTRL, 32'h1);
    host.wr(ao_seq_pkg::REG_RATE, 32'h0);
    host.rd(ao_seq_pkg::REG_RATE, d);
    `CHK(d, 32'(ao_seq_pkg::DIV_MIN))
    host.wr(ao_seq_pkg::REG_FDATA, 32'hA0000001);
    host.wr(ao_seq_pkg::REG_FDATA, 32'h50000002);
    host.wr(ao_seq_pkg::REG_CMD, 32'h1);
    wait_load(12000);
    `CHK(c >= 36 * 223, 1'h1)
    `CHK(dac_code0, 32'hA0000001)
    wait_load(600);
    `CHK(dac_code0, 32'h50000002)
    wait_load(600);
    `CHK(dac_code0, 32'hA0000001)
    host.wr(ao_seq_pkg::REG_CMD, 32'h8);
    wait_load(600);
    `CHK(c, 600)
    host.wr(ao_seq_pkg::REG_CMD, 32'h1);
    repeat (3) @(posedge mclk);
    `CHK(running, 1'h0)
  endtask : t_wave

  task automatic t_cont();
    host.wr(ao_seq_pkg::REG_CTRL, 32'h6);
    host.wr(ao_seq_pkg::REG_CMD, 32'h10);
    host.wr(ao_seq_pkg::REG_FDATA, 32'h7FFFFFFF);
    host.wr(ao_seq_pkg::REG_CMD, 32'h1);
    repeat (3) @(posedge mclk);
    `CHK(running, 1'h0)
    ext_trig <= 1'h1;
    repeat (4) @(posedge mclk);
    `CHK(running, 1'h1)
    wait_load(12000);
    `CHK(dac_code0, 32'h7FFFFFFF)
    c = 0;
    while (underrun_evt !== 1'h1 && c < 600) begin
      @(posedge mclk);
      #1 c++;
    end
    `CHK(underrun_evt, 1'h1)
    host.rd(ao_seq_pkg::REG_STATUS, d);
    `CHK(d[4], 1'h1)
  endtask : t_cont

  task automatic t_dual();
    host.wr(ao_seq_pkg::REG_CTRL, 32'h142);
    host.wr(ao_seq_pkg::REG_CMD, 32'h10);
    `CHK(range_wide, 1'h1)
    host.wr(ao_seq_pkg::REG_FDATA, 32'h11111111);
    host.wr(ao_seq_pkg::REG_FDATA, 32'h22222222);
    host.wr(ao_seq_pkg::REG_FDATA, 32'h33333333);
    host.wr(ao_seq_pkg::REG_FDATA, 32'h44444444);
    host.wr(ao_seq_pkg::REG_STOPN, 32'h2);
    host.wr(ao_seq_pkg::REG_CMD, 32'h2);
    #1 `CHK(ai_start, 1'h1)
    host.rd(ao_seq_pkg::REG_STATUS, d);
    `CHK(d[4], 1'h0)
    host.wr(ao_seq_pkg::REG_CMD, 32'h4);
    wait_load(12000);
    `CHK(dac_code0, 32'h11111111)
    @(posedge mclk);
    #1 `CHK(dac_load1, 1'h1)
    `CHK(dac_code1, 32'h22222222)
    wait_load(600);
    `CHK(c, 600)
    `CHK(running, 1'h0)
  endtask : t_dual

  task automatic t_slave();
    host.wr(ao_seq_pkg::REG_CTRL, 32'h26);
    host.wr(ao_seq_pkg::REG_CMD, 32'h1);
    ext_trig <= 1'h0;
    repeat (2) @(posedge mclk);
    ext_trig <= 1'h1;
    repeat (3) @(posedge mclk);
    `CHK(running, 1'h0)
    strig <= 1'h1;
    repeat (3) @(posedge mclk);
    `CHK(running, 1'h1)
    repeat (36) begin
      sclk <= 1'h1;
      @(posedge mclk);
      sclk <= 1'h0;
      @(posedge mclk);
    end
    sclk <= 1'h1;
    wait_load(8);
    `CHK(dac_code0, 32'h33333333)
    host.wr(ao_seq_pkg::REG_FDATA, 32'hC0000000);
    host.wr(ao_seq_pkg::REG_FDATA, 32'hC0000000);
    host.wr(ao_seq_pkg::REG_CTRL, 32'hA6);
    link_tick();
    `CHK(dac_code0, 32'h44444444)
    link_tick();
    `CHK(dac_code0, 32'hBFEFEFEF)
    host.wr(ao_seq_pkg::REG_CTRL, 32'h26);
    link_tick();
    `CHK(dac_code0, 32'hC0000000)
  endtask : t_slave

  initial begin
    t_reset();
    t_single();
    t_wave();
    t_cont();
    t_dual();
    t_slave();
    stop_test();
  end
endmodule : testbench
